// File: src/buck_seq_pkg.sv
// Shared constants for the triple buck sequencer.
package buck_seq_pkg;
  localparam int NCH = 3;
  // Switching period in clock cycles and the one-third offset between phases.
  localparam int PERIOD = 12;
  localparam logic [7:0] PERIOD_M1 = 8'h0b;
  localparam logic [7:0] PHASE_STEP = 8'h04;
  // Maximum on-time in cycles (about five sixths of a period).
  localparam logic [7:0] MAX_ON = 8'h0a;
  // Soft-start ramp length in milliseconds; the demand rises one step each 1/256 of it.
  localparam real SOFT_START_MS = 1.25;
  localparam real CLK_MHZ = 200.0;
  localparam int SOFT_START_CYC = int'(SOFT_START_MS * CLK_MHZ * 1000.0);
  localparam logic [7:0] DEMAND_FULL = 8'hff;
  // Power-good delay scale: seconds per farad, and the default delay in cycles.
  localparam real DELAY_SCALE = 2.131e5;
  localparam real DELAY_CAP_F = 470.0e-9;
  localparam int DELAY_CYC = int'(DELAY_SCALE * DELAY_CAP_F * CLK_MHZ * 1.0e6);
  // AXI4-Lite register byte addresses.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_DELAY = 8'h08;
  localparam logic [7:0] ADDR_DEMAND = 8'h0c;
  // Control register fields.
  localparam int CTRL_EXT_SUPPLY = 0;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Status register field positions.
  localparam int ST_ENABLED = 0;
  localparam int ST_RUNNING = 4;
  localparam int ST_GOOD = 8;
  localparam int ST_SUPPLY_OK = 9;
  localparam int ST_TIMING = 10;
  localparam int ST_EXT_SUPPLY = 11;
endpackage

// File: src/sync2.sv
// Two-flop synchroniser for a bundle of asynchronous levels.
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // First stage, read only by the second stage.
  logic [W-1:0] meta;

  // Both stages hold while the clock enable is low.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= '0;
      q <= '0;
    end else if (ce) begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// File: src/buck_channel.sv
// One buck channel: soft-start ramp, peak-current on-time and pulse skipping.
`timescale 1ns/1ps
module buck_channel
  import buck_seq_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic run,
  input wire logic period_start,
  input wire logic [7:0] on_cnt_max,
  input wire logic current_trip,
  input wire logic min_duty_low,
  output logic gate_on,
  output logic [7:0] demand,
  output logic ramping
);
  // Prescaler for the ramp, counting cycles between demand steps.
  logic [31:0] ramp_div;
  // Cycles spent in the present on-time.
  logic [7:0] on_cnt;

  // Soft start: demand climbs from zero whenever the channel starts fresh.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      demand <= 8'h00;
      ramp_div <= 32'h0;
    end else if (ce) begin
      if (!run) begin
        demand <= 8'h00;
        ramp_div <= 32'h0;
      end else if (demand != DEMAND_FULL) begin
        if (ramp_div >= 32'(SOFT_START_CYC / 256)) begin
          ramp_div <= 32'h0;
          demand <= demand + 8'h01;
        end else begin
          ramp_div <= ramp_div + 32'h1;
        end
      end
    end
  end

  assign ramping = run && (demand != DEMAND_FULL);

  // Switch turns on at each period start and ends on the current trip or the on-time limit.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate_on <= 1'b0;
      on_cnt <= 8'h00;
    end else if (ce) begin
      if (!run) begin
        gate_on <= 1'b0;
        on_cnt <= 8'h00;
      end else if (period_start) begin
        // A too-short pulse is skipped outright to keep regulation.
        gate_on <= !min_duty_low;
        on_cnt <= 8'h00;
      end else if (gate_on) begin
        on_cnt <= on_cnt + 8'h01;
        if (current_trip || on_cnt >= on_cnt_max) begin
          gate_on <= 1'b0;
        end
      end
    end
  end
endmodule

// File: src/triple_buck_por_sequencer.sv
// Top of the triple buck sequencer: phasing, supply lockout and power-good.
`timescale 1ns/1ps
module triple_buck_por_sequencer
  import buck_seq_pkg::*;
#(
  parameter logic [31:0] DELAY_DEFAULT = 32'(DELAY_CYC)
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic channel1_enable,
  input wire logic channel2_enable,
  input wire logic channel3_enable,
  input wire logic supply_startup_level,
  input wire logic supply_shutdown_level,
  input wire logic ext_supply_shutdown_level,
  input wire logic supply_warning_level,
  input wire logic gate_pump_ok,
  input wire logic ext_logic_supply,
  input wire logic thermal_shutdown,
  input wire logic [2:0] feedback_above_upper,
  input wire logic [2:0] feedback_above_lower,
  input wire logic [2:0] current_trip,
  input wire logic [2:0] min_duty_low,
  output logic [2:0] gate_on,
  output logic gate_pump_run,
  output logic power_good_n_flag_o,
  output logic power_good_n_flag_oe,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // Supply states from power-on through running.
  typedef enum logic [1:0] {
    PWR_OFF,
    PWR_PUMP,
    PWR_RUN
  } pwr_e;

  // Power-good states: low, timing, released.
  typedef enum logic [1:0] {
    PG_LOW,
    PG_TIMING,
    PG_HIGH
  } pg_e;

  // Synchronised analogue comparator and pin levels.
  logic [2:0] en_s;
  logic [5:0] sup_s;
  logic [2:0] up_s;
  logic [2:0] lo_s;
  logic [2:0] trip_s;
  logic [2:0] skip_s;
  logic ext_sup_s;
  // Supply sequencing state.
  pwr_e pwr;
  // Follows the external logic supply level, one cycle behind the synchroniser.
  logic ext_active;
  // Phase counter shared by all three channels.
  logic [7:0] phase;
  // Per-channel run and start strobes.
  logic [2:0] run;
  logic [2:0] period_start;
  logic [2:0] ramping;
  logic [7:0] demand [NCH];
  // Enable history, to spot a newly enabled channel.
  logic [2:0] en_q;
  // Power-good state, counter and the software-set delay.
  pg_e pg;
  logic [31:0] pg_cnt;
  logic [31:0] delay_cfg;
  // Software controls: on-time cap.
  logic [7:0] on_max;
  // Qualification terms.
  logic all_upper;
  logic any_low;
  logic new_enable;
  logic shutdown;
  // Bus latches for the write path.
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // Every asynchronous input except gate_pump_ok passes two flops.
  sync2 #(.W(3)) u_sync_en (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .d({channel3_enable, channel2_enable, channel1_enable}),
    .q(en_s)
  );
  sync2 #(.W(6)) u_sync_sup (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .d({ext_logic_supply, thermal_shutdown, supply_warning_level,
        ext_supply_shutdown_level, supply_shutdown_level, supply_startup_level}),
    .q(sup_s)
  );
  sync2 #(.W(12)) u_sync_fb (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .d({min_duty_low, current_trip, feedback_above_lower, feedback_above_upper}),
    .q({skip_s, trip_s, lo_s, up_s})
  );
  assign ext_sup_s = sup_s[5];

  // Shutdown uses the level that matches the present logic supply source.
  assign shutdown = sup_s[4] ||
    (ext_active ? !sup_s[2] : !sup_s[1]);

  // The lower external-supply level applies only while that supply is present.
  // Until it appears, as at first power, the internal levels govern the supply.
  // Following the level instead of latching it restores the higher level if it goes away.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_active <= 1'b0;
    end else if (ce) begin
      // One more register stage: the source switch lags the synchroniser by a cycle.
      ext_active <= ext_sup_s;
    end
  end

  // Startup: wait for startup level, run pump, then release the channels.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr <= PWR_OFF;
    end else if (ce) begin
      case (pwr)
        PWR_OFF: if (sup_s[0] && !sup_s[4]) begin
          pwr <= PWR_PUMP;
        end
        PWR_PUMP: if (shutdown) begin
          pwr <= PWR_OFF;
        end else if (gate_pump_ok) begin
          pwr <= PWR_RUN;
        end
        PWR_RUN: if (shutdown) begin
          // Dropping to OFF clears every ramp, so recovery soft-starts.
          pwr <= PWR_OFF;
        end
        default: pwr <= PWR_OFF;
      endcase
    end
  end
  assign gate_pump_run = (pwr != PWR_OFF);

  // One shared phase counter drives all periods.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase <= 8'h00;
    end else if (ce) begin
      phase <= (phase == PERIOD_M1) ? 8'h00 : phase + 8'h01;
    end
  end

  // Channels share the clock, each starting a third of a period apart.
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : gen_ch
      assign run[g] = en_s[g] && (pwr == PWR_RUN);
      assign period_start[g] = (phase == 8'(g) * PHASE_STEP);
      buck_channel u_ch (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .run(run[g]),
        .period_start(period_start[g]),
        .on_cnt_max(on_max),
        .current_trip(trip_s[g]),
        .min_duty_low(skip_s[g]),
        .gate_on(gate_on[g]),
        .demand(demand[g]),
        .ramping(ramping[g])
      );
    end
  endgenerate

  // Only enabled channels take part in qualification.
  assign all_upper = ((up_s | ~en_s) == 3'b111) && (en_s != 3'b000);
  assign any_low = |(en_s & ~lo_s);
  assign new_enable = |(en_s & ~en_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_q <= 3'b000;
    end else if (ce) begin
      en_q <= en_s;
    end
  end

  // Power-good: timer runs once qualified, flag released at its end.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pg <= PG_LOW;
      pg_cnt <= 32'h0;
    end else if (ce) begin
      if (pwr != PWR_RUN || !sup_s[3] || en_s == 3'b000 || new_enable) begin
        pg <= PG_LOW;
        pg_cnt <= 32'h0;
      end else begin
        case (pg)
          PG_LOW: if (all_upper) begin
            pg <= PG_TIMING;
            pg_cnt <= 32'h0;
          end
          PG_TIMING: if (!all_upper && any_low) begin
            pg <= PG_LOW;
          end else if (pg_cnt + 32'h1 >= delay_cfg) begin
            pg <= any_low ? PG_LOW : PG_HIGH;
          end else begin
            pg_cnt <= pg_cnt + 32'h1;
          end
          PG_HIGH: if (any_low) begin
            pg <= PG_LOW;
          end
          default: pg <= PG_LOW;
        endcase
      end
    end
  end

  // Open drain: pull low unless good.
  assign power_good_n_flag_o = 1'b0;
  assign power_good_n_flag_oe = (pg != PG_HIGH);

  // Write path: address and data taken in either order.
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_held && w_held) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr == ADDR_DELAY || aw_addr == ADDR_DEMAND) ?
          RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Writable registers: delay count and on-time limit.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      delay_cfg <= DELAY_DEFAULT;
      on_max <= MAX_ON;
    end else if (ce && aw_held && w_held) begin
      if (aw_addr == ADDR_DELAY) begin
        for (int b = 0; b < 4; b++) begin
          if (w_strb[b]) begin
            delay_cfg[8*b +: 8] <= w_data[8*b +: 8];
          end
        end
      end else if (aw_addr == ADDR_DEMAND && w_strb[0]) begin
        on_max <= w_data[7:0];
      end
    end
  end

  // Read path: one read at a time, answer the cycle after the address.
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        case (s_axi_araddr)
          ADDR_CTRL: s_axi_rdata <= {31'h0, ext_active};
          ADDR_STATUS: s_axi_rdata <= {20'h0, ext_active, pg == PG_TIMING,
            !shutdown, pg == PG_HIGH, 1'b0, ramping, 1'b0, en_s};
          ADDR_DELAY: s_axi_rdata <= delay_cfg;
          ADDR_DEMAND: s_axi_rdata <= {8'h00, demand[2], demand[1], on_max};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// File: verif/seq_checker_assertions.sv
// Checker of flag, switching and register-bus timing at the sequencer's ports.
`timescale 1ns/1ps
module seq_checker
  import buck_seq_pkg::*;
#(
  parameter logic [31:0] DELAY_DEFAULT = 32'h10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic channel1_enable,
  input wire logic channel2_enable,
  input wire logic channel3_enable,
  input wire logic supply_warning_level,
  input wire logic thermal_shutdown,
  input wire logic [2:0] feedback_above_upper,
  input wire logic [2:0] feedback_above_lower,
  input wire logic [2:0] gate_on,
  input wire logic power_good_n_flag_oe,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic [2:0] en;
  logic qual;
  logic [15:0] run_cnt;
  assign en = {channel3_enable, channel2_enable, channel1_enable};
  assign qual = (en != 3'h0) && ((en & ~feedback_above_upper) == 3'h0)
    && supply_warning_level;
  // Raw inputs lead the synchronised ones, so the design's count is never longer than this.
  always_ff @(posedge aclk) begin
    if (!aresetn || !qual) begin
      run_cnt <= 16'h0000;
    end else if (run_cnt != 16'hffff) begin
      run_cnt <= run_cnt + 16'h0001;
    end
  end
  sequence hot_s;
    thermal_shutdown [*6];
  endsequence
  sequence warn_s;
    !supply_warning_level [*5];
  endsequence
  sequence idle_s;
    (en == 3'h0) [*5];
  endsequence
  sequence sag_s;
    ((en & ~feedback_above_lower) != 3'h0) [*5];
  endsequence
  thermal_stop_a: assert property (hot_s |-> gate_on == 3'h0 && power_good_n_flag_oe)
    else $error("switching or flag released during overtemperature");
  warn_flag_a: assert property (warn_s |-> power_good_n_flag_oe)
    else $error("flag released below warning level");
  idle_flag_a: assert property (idle_s |-> power_good_n_flag_oe)
    else $error("flag released with no channel enabled");
  sag_flag_a: assert property (sag_s |-> power_good_n_flag_oe)
    else $error("flag released with enabled feedback below lower level");
  release_cause_a: assert property ($fell(power_good_n_flag_oe) |->
    $past(supply_warning_level, 3) && (($past(en, 3) & ~$past(feedback_above_lower, 3)) == 3'h0))
    else $error("flag released while a cause still holds");
  timer_len_a: assert property ($fell(power_good_n_flag_oe) |-> run_cnt >= DELAY_DEFAULT[15:0])
    else $error("flag released before the delay elapsed");
  phase_split_a: assert property ($onehot0({$rose(gate_on[2]), $rose(gate_on[1]),
    $rose(gate_on[0])}))
    else $error("two channels started in the same cycle");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  aw_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address accepted while response pending");
endmodule

bind triple_buck_por_sequencer seq_checker #(.DELAY_DEFAULT(DELAY_DEFAULT)) chk (.aclk,
  .aresetn, .channel1_enable, .channel2_enable, .channel3_enable, .supply_warning_level,
  .thermal_shutdown, .feedback_above_upper, .feedback_above_lower, .gate_on,
  .power_good_n_flag_oe, .s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

// File: verif/sys_ctrl_model.sv
// Model of the system controller that drives the enables and reads the flag.
`timescale 1ns/1ps
module sys_ctrl_model (
  input wire logic aclk,
  input wire logic [2:0] want,
  input wire logic refresh,
  input wire logic power_good_n_flag_o,
  input wire logic power_good_n_flag_oe,
  output logic channel1_enable,
  output logic channel2_enable,
  output logic channel3_enable,
  output logic power_good
);
  logic [3:0] hold = 4'h0;
  initial {channel3_enable, channel2_enable, channel1_enable} = 3'h0;
  // The flag line has a pull-up, so it reads high whenever nobody pulls it.
  assign power_good = power_good_n_flag_oe ? power_good_n_flag_o : 1'b1;
  // A refresh drops the enables for a while to force a fresh ramp, then restores them.
  always @(posedge aclk) begin
    if (refresh) begin
      hold <= 4'hf;
    end else if (hold != 4'h0) begin
      hold <= hold - 4'h1;
    end
    {channel3_enable, channel2_enable, channel1_enable} <=
      (refresh || hold != 4'h0) ? 3'h0 : want;
  end
endmodule

// File: verif/tb_top.sv
// Self-checking bench for the triple buck sequencer.
`timescale 1ns/1ps
module tb_top;
  import buck_seq_pkg::*;
  localparam logic [31:0] DLY = 32'h10;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, refresh = 1'b0, pg;
  logic supply_startup_level = 1'b0, supply_shutdown_level = 1'b1, gate_pump_ok = 1'b0;
  logic ext_supply_shutdown_level = 1'b1, supply_warning_level = 1'b1;
  logic ext_logic_supply = 1'b0, thermal_shutdown = 1'b0, gate_pump_run;
  logic channel1_enable, channel2_enable, channel3_enable;
  logic [2:0] want = 3'h1, good = 3'h0, min_duty_low = 3'h0, gate_on;
  logic [2:0] feedback_above_upper = 3'h0, feedback_above_lower = 3'h0, current_trip = 3'h0;
  logic power_good_n_flag_o, power_good_n_flag_oe;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int num_errors = 0, samples_checked = 0, cycles = 0;
  triple_buck_por_sequencer #(.DELAY_DEFAULT(DLY)) DUT (.aclk, .aresetn, .ce,
    .channel1_enable, .channel2_enable, .channel3_enable, .supply_startup_level,
    .supply_shutdown_level, .ext_supply_shutdown_level, .supply_warning_level, .gate_pump_ok,
    .ext_logic_supply, .thermal_shutdown, .feedback_above_upper, .feedback_above_lower,
    .current_trip, .min_duty_low, .gate_on, .gate_pump_run, .power_good_n_flag_o,
    .power_good_n_flag_oe, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  sys_ctrl_model PC (.aclk, .want, .refresh, .power_good_n_flag_o, .power_good_n_flag_oe,
    .channel1_enable, .channel2_enable, .channel3_enable, .power_good(pg));
  always #2.5 aclk = ~aclk;
  // Disabled channels get random feedback, which must never reach the flag.
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    feedback_above_upper <= (good & want) | (3'($urandom) & ~want);
    feedback_above_lower <= (good & want) | (3'($urandom) & ~want);
    current_trip <= 3'($urandom) & 3'($urandom);
    if (cycles == 20000) begin
      num_errors++;
      conclude();
    end
  end
  task automatic conclude();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({31'h0, got}, {31'h0, exp});
  endtask
  // Mapped registers answer OKAY on a read, anything else SLVERR.
  function automatic logic [1:0] rd_resp(input logic [7:0] a);
    return (a == ADDR_CTRL || a == ADDR_STATUS || a == ADDR_DELAY || a == ADDR_DEMAND) ?
      RESP_OKAY : RESP_SLVERR;
  endfunction
  // Write with address and data offered together; each is dropped once taken.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    cmp_word({30'h0, s_axi_bresp}, {30'h0, e});
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    cmp_word({30'h0, s_axi_rresp}, {30'h0, rd_resp(a)});
    s_axi_rready <= 1'b0;
  endtask
  task automatic watch(input int n, output logic [2:0] seen);
    seen = 3'h0;
    repeat (n) begin
      @(posedge aclk);
      seen = seen | gate_on;
    end
  endtask
  // Bounded wait for the flag to reach a level, then a comparison.
  task automatic wait_pg(input logic e, input int n);
    int k;
    k = 0;
    while (pg !== e && k < n) begin
      @(posedge aclk);
      k++;
    end
    cmp_bit(pg, e);
  endtask
  initial begin
    logic [31:0] d;
    logic [2:0] s;
    void'($urandom(32'h11e3096b));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(ADDR_DELAY, d);
    cmp_word(d, DLY);
    axi_wr(ADDR_DELAY, 32'h18, RESP_OKAY);
    axi_rd(ADDR_DELAY, d);
    cmp_word(d, 32'h18);
    axi_wr(ADDR_STATUS, 32'h0, RESP_SLVERR);
    axi_rd(8'h10, d);
    cmp_word(d, 32'h0);
    axi_wr(ADDR_DEMAND, 32'h9, RESP_OKAY);
    axi_rd(ADDR_DEMAND, d);
    cmp_word(d, 32'h9);
    watch(20, s);
    cmp_bit(gate_pump_run, 1'b0);
    supply_startup_level <= 1'b1;
    watch(20, s);
    cmp_word({gate_pump_run, s}, 32'h8);
    gate_pump_ok <= 1'b1;
    watch(40, s);
    cmp_word(s, 3'h1);
    axi_rd(ADDR_STATUS, d);
    cmp_word(d[8:0], 32'h11);
    min_duty_low <= 3'h1;
    watch(12, s);
    watch(36, s);
    cmp_bit(s[0], 1'b0);
    min_duty_low <= 3'h0;
    good <= 3'h7;
    watch(12, s);
    cmp_bit(pg, 1'b0);
    wait_pg(1'b1, 100);
    want <= 3'h3;
    good <= 3'h1;
    wait_pg(1'b0, 10);
    watch(24, s);
    cmp_word(s, 3'h3);
    good <= 3'h7;
    wait_pg(1'b1, 100);
    good <= 3'h6;
    wait_pg(1'b0, 10);
    watch(24, s);
    cmp_word(s, 3'h3);
    good <= 3'h7;
    wait_pg(1'b1, 100);
    supply_warning_level <= 1'b0;
    wait_pg(1'b0, 10);
    watch(24, s);
    cmp_word(s, 3'h3);
    supply_warning_level <= 1'b1;
    ext_logic_supply <= 1'b1;
    watch(12, s);
    supply_shutdown_level <= 1'b0;
    watch(12, s);
    watch(24, s);
    cmp_word(s, 3'h3);
    axi_rd(ADDR_CTRL, d);
    cmp_bit(d[0], 1'b1);
    ext_logic_supply <= 1'b0;
    watch(12, s);
    watch(24, s);
    cmp_word(s, 3'h0);
    supply_shutdown_level <= 1'b1;
    wait_pg(1'b1, 300);
    thermal_shutdown <= 1'b1;
    watch(6, s);
    watch(24, s);
    cmp_word({pg, s}, 32'h0);
    thermal_shutdown <= 1'b0;
    watch(40, s);
    cmp_word(s, 3'h3);
    axi_rd(ADDR_STATUS, d);
    cmp_word(d[6:4], 32'h3);
    wait_pg(1'b1, 300);
    refresh <= 1'b1;
    @(posedge aclk);
    refresh <= 1'b0;
    wait_pg(1'b0, 20);
    ce <= 1'b0;
    watch(60, s);
    cmp_bit(pg, 1'b0);
    ce <= 1'b1;
    wait_pg(1'b1, 300);
    want <= 3'h0;
    wait_pg(1'b0, 10);
    conclude();
  end
endmodule
